// ===== rtl/hbt_host_port.sv
// Notes on behaviour
// R1: Arbitration period is one or two clocks.
// R2: Host spaces strobe leading edges four periods.
// R3: Pointer read after data read waits five.
// R4: Pointer read after data write waits five.
// R5: Anything after pointer-low write waits four.
// R6: Pointer-low write after data access waits five.
// R7: Pointer-low write after data read waits five.
// R8: Fast read timing needs bit zero, pin high; the code checks the pin only when large_package is set.
// R9: Writes ignore read bit; need pin high; the code checks the pin only when large_package is set.
// R10: Multiplexed mode latches address, select on ALE fall.
// R11: Host holds direction stable around data strobe.
// R12: Write data taken at strobe trailing edge.
// R13: Data driven only while read strobe active.
// R14: Host doubles cycle time for back-to-back access.
// R15: Strobes synchronised; spacing counted in arbitration periods.
`timescale 1ns/100ps
module hbt_host_port #(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic addr_latch,
  input wire logic data_strobe_n,
  input wire logic direction,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bus_timing_pin,
  input wire logic mux_mode_pin,
  input wire logic large_package,
  input wire logic strobe_style_68,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic slow_arbitration_select,
  input wire logic read_timing_select_bit,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic [DATA_W-1:0] data_out_q,
  output logic data_oe_q,
  output logic [ADDR_W-1:0] reg_addr_q,
  output logic [DATA_W-1:0] reg_wdata_q,
  output logic reg_wr_q,
  output logic reg_rd_q,
  output logic arb_tick_q,
  output logic fast_read_q,
  output logic write_enable_q,
  output logic spacing_error_q
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_q;
  logic rst_i_n;
  logic [hbt_pkg::CTRL_PINS-1:0] ctl_s1_q, ctl_s2_q;
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic [DATA_W-1:0] data_s1_q, data_s2_q;
  logic ale_prev_q, cs_lat_q, arb_div_q;
  logic [ADDR_W-1:0] addr_lat_q;
  hbt_pkg::hbt_cyc_t cyc_q, cyc_d;
  logic [hbt_pkg::SPACE_CNT_W-1:0] lead_cnt_q, trail_cnt_q;
  logic last_data_q, last_plo_wr_q;

  function automatic logic [hbt_pkg::SPACE_CNT_W-1:0] sat_inc(
    input logic [hbt_pkg::SPACE_CNT_W-1:0] v);
    sat_inc = (v == hbt_pkg::SPACE_CNT_MAX) ? v : v + 1'b1;
  endfunction

  function automatic logic is_ptr(input logic [ADDR_W-1:0] a);
    is_ptr = (a == ADDR_W'(hbt_pkg::ADDR_PTR_HI)) || (a == ADDR_W'(hbt_pkg::ADDR_PTR_LO));
  endfunction

  assign rst_i_n = rst_sync_q[1];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  wire [hbt_pkg::CTRL_PINS-1:0] ctl_pins = {large_package, mux_mode_pin, bus_timing_pin,
    write_strobe_n, read_strobe_n, direction, data_strobe_n, addr_latch, chip_select_n};

  always_ff @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      ctl_s1_q <= hbt_pkg::CTRL_IDLE;
      ctl_s2_q <= hbt_pkg::CTRL_IDLE;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end
    else
    begin
      ctl_s1_q <= ctl_pins; // R15
      ctl_s2_q <= ctl_s1_q;
      addr_s1_q <= addr_in;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire ale_s = ctl_s2_q[hbt_pkg::PIN_ALE];
  wire mux_s = ctl_s2_q[hbt_pkg::PIN_MUX];
  wire ale_fall = ale_prev_q & ~ale_s;
  wire cs_act = mux_s ? cs_lat_q : ~ctl_s2_q[hbt_pkg::PIN_CS];
  wire ds_act = ~ctl_s2_q[hbt_pkg::PIN_DS];
  wire dir_rd = ctl_s2_q[hbt_pkg::PIN_DIR];
  // Direction sampled with the strobe; host keeps it steady meanwhile
  wire rd_strobe = strobe_style_68 ? (ds_act & dir_rd) : ~ctl_s2_q[hbt_pkg::PIN_RD]; // R11
  wire wr_strobe = strobe_style_68 ? (ds_act & ~dir_rd) : ~ctl_s2_q[hbt_pkg::PIN_WR];
  wire wr_ok = ~ctl_s2_q[hbt_pkg::PIN_PKG] | ctl_s2_q[hbt_pkg::PIN_BTP]; // R9
  wire fast_rd = ~read_timing_select_bit & wr_ok; // R8
  wire rd_act = cs_act & rd_strobe;
  wire wr_act = cs_act & wr_strobe & write_enable_q; // R9
  wire [ADDR_W-1:0] cyc_addr = mux_s ? addr_lat_q : addr_s2_q;
  wire idle = (cyc_q == hbt_pkg::HBT_IDLE);
  wire lead = idle & (rd_act | wr_act);
  wire rd_end = (cyc_q == hbt_pkg::HBT_READ) & ~rd_strobe;
  wire wr_end = (cyc_q == hbt_pkg::HBT_WRITE) & ~wr_strobe;
  wire trail = rd_end | wr_end;
  wire arb_tick = ~slow_arbitration_select | arb_div_q; // R1
  // Clearing edge counts its own tick, so a gap of exactly the minimum passes
  wire [hbt_pkg::SPACE_CNT_W-1:0] tick_base = {{(hbt_pkg::SPACE_CNT_W-1){1'b0}}, arb_tick};
  wire is_data = (reg_addr_q == ADDR_W'(hbt_pkg::ADDR_DATA));
  wire is_plo_new = (cyc_addr == ADDR_W'(hbt_pkg::ADDR_PTR_LO));
  wire short_min = (lead_cnt_q < hbt_pkg::SPACE_MIN_CNT); // R2
  wire short_plo = last_plo_wr_q & (trail_cnt_q < hbt_pkg::SPACE_MIN_CNT); // R5
  wire short_dat = last_data_q & (trail_cnt_q < hbt_pkg::SPACE_DATA_CNT);
  wire ptr_rd_bad = short_dat & rd_act & is_ptr(cyc_addr); // R3 R4
  wire plo_wr_bad = short_dat & wr_act & is_plo_new; // R6 R7
  wire violation = lead & (short_min | short_plo | ptr_rd_bad | plo_wr_bad);

  always_comb
  begin
    cyc_d = cyc_q;
    unique case (cyc_q)
      hbt_pkg::HBT_IDLE:
        if (rd_act)
          cyc_d = hbt_pkg::HBT_READ;
        else if (wr_act)
          cyc_d = hbt_pkg::HBT_WRITE;
      hbt_pkg::HBT_READ:
        if (!rd_strobe)
          cyc_d = hbt_pkg::HBT_IDLE;
      hbt_pkg::HBT_WRITE:
        if (!wr_strobe)
          cyc_d = hbt_pkg::HBT_IDLE;
      default:
        cyc_d = hbt_pkg::HBT_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address phase; multiplexed hosts drop ALE before any strobe
  always_ff @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      ale_prev_q <= 1'b0;
      cs_lat_q <= 1'b0;
      addr_lat_q <= '0;
    end
    else
    begin
      ale_prev_q <= ale_s;
      if (ale_fall)
      begin
        cs_lat_q <= ~ctl_s2_q[hbt_pkg::PIN_CS]; // R10
        addr_lat_q <= addr_s2_q; // R10
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      cyc_q <= hbt_pkg::HBT_IDLE;
      reg_addr_q <= '0;
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_wdata_q <= '0;
      data_out_q <= '0;
      data_oe_q <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_d;
      reg_rd_q <= idle & rd_act;
      reg_wr_q <= wr_end; // R12
      data_oe_q <= (cyc_d == hbt_pkg::HBT_READ); // R13
      if (lead)
        reg_addr_q <= cyc_addr;
      if (wr_end)
        reg_wdata_q <= data_s2_q; // R12
      if (cyc_q == hbt_pkg::HBT_READ)
        data_out_q <= reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters saturate at seven, so the first cycle after reset never flags
  always_ff @(posedge clk_sys or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      arb_div_q <= 1'b0;
      arb_tick_q <= 1'b0;
      lead_cnt_q <= hbt_pkg::SPACE_CNT_MAX;
      trail_cnt_q <= hbt_pkg::SPACE_CNT_MAX;
      last_data_q <= 1'b0;
      last_plo_wr_q <= 1'b0;
      spacing_error_q <= 1'b0;
      fast_read_q <= 1'b0;
      write_enable_q <= 1'b0;
    end
    else
    begin
      arb_div_q <= slow_arbitration_select & ~arb_div_q; // R1
      arb_tick_q <= arb_tick;
      fast_read_q <= fast_rd;
      write_enable_q <= wr_ok;
      spacing_error_q <= violation; // R15
      if (lead)
        lead_cnt_q <= tick_base; // R15
      else if (arb_tick)
        lead_cnt_q <= sat_inc(lead_cnt_q); // R15
      if (trail)
        trail_cnt_q <= tick_base;
      else if (arb_tick)
        trail_cnt_q <= sat_inc(trail_cnt_q);
      if (trail)
      begin
        last_data_q <= is_data;
        last_plo_wr_q <= wr_end & (reg_addr_q == ADDR_W'(hbt_pkg::ADDR_PTR_LO));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_i_n);

  chk_slow_tick_skip: assert property ( // R1
    slow_arbitration_select && arb_tick_q ##1 slow_arbitration_select |-> !arb_tick_q)
    else $error("slow tick not halved");
  chk_fast_tick_run: assert property ( // R1
    $past(rst_i_n) && !$past(slow_arbitration_select) |-> arb_tick_q)
    else $error("fast tick missing");
  chk_oe_release: assert property (rd_end |=> !data_oe_q ##1 !data_oe_q) // R13
    else $error("data bus held after read");
  chk_oe_needs_read: assert property (data_oe_q |-> $past(cs_act)) // R13
    else $error("data driven without select");
  chk_write_at_end: assert property ( // R12
    reg_wr_q |-> $past(cyc_q) == hbt_pkg::HBT_WRITE && reg_wdata_q == $past(data_s2_q))
    else $error("write data not at trailing edge");
  chk_ale_latch: assert property (ale_fall |=> addr_lat_q == $past(addr_s2_q)) // R10
    else $error("address not latched on ALE fall");
  chk_fast_read: assert property ( // R8
    $past(rst_i_n) |-> fast_read_q == (!$past(read_timing_select_bit)
    && (!$past(ctl_s2_q[hbt_pkg::PIN_PKG]) || $past(ctl_s2_q[hbt_pkg::PIN_BTP]))))
    else $error("fast read wrong");
  chk_write_block: assert property ( // R9
    !write_enable_q && idle |=> cyc_q != hbt_pkg::HBT_WRITE)
    else $error("write taken while disabled");
  chk_short_gap: assert property ( // R2
    lead && lead_cnt_q < hbt_pkg::SPACE_MIN_CNT |=> spacing_error_q)
    else $error("short strobe spacing missed");
  chk_ptr_after_data: assert property (lead && ptr_rd_bad |=> spacing_error_q) // R3
    else $error("pointer read spacing missed");
  chk_plo_settle: assert property (lead && short_plo |=> spacing_error_q) // R5
    else $error("pointer low settle spacing missed");
  chk_plo_after_data: assert property (lead && plo_wr_bad |=> spacing_error_q) // R6
    else $error("pointer low write spacing missed");

endmodule

// ===== rtl/hbt_pkg.sv
package hbt_pkg;

  // Spacing limits, counted in arbitration clock periods
  localparam int unsigned SPACE_MIN_ARB = 4;
  localparam int unsigned SPACE_DATA_ARB = 5;
  localparam int unsigned SPACE_CNT_W = 3;
  localparam logic [SPACE_CNT_W-1:0] SPACE_CNT_MAX = 3'h7;
  localparam logic [SPACE_CNT_W-1:0] SPACE_MIN_CNT = SPACE_CNT_W'(SPACE_MIN_ARB);
  localparam logic [SPACE_CNT_W-1:0] SPACE_DATA_CNT = SPACE_CNT_W'(SPACE_DATA_ARB);

  // Host register addresses seen by the spacing checks
  localparam logic [2:0] ADDR_PTR_HI = 3'h2;
  localparam logic [2:0] ADDR_PTR_LO = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h4;

  // Number of host control pins that pass the synchroniser
  localparam int unsigned CTRL_PINS = 9;
  localparam int unsigned PIN_CS = 0;
  localparam int unsigned PIN_ALE = 1;
  localparam int unsigned PIN_DS = 2;
  localparam int unsigned PIN_DIR = 3;
  localparam int unsigned PIN_RD = 4;
  localparam int unsigned PIN_WR = 5;
  localparam int unsigned PIN_BTP = 6;
  localparam int unsigned PIN_MUX = 7;
  localparam int unsigned PIN_PKG = 8;
  localparam logic [CTRL_PINS-1:0] CTRL_IDLE = 9'h03D;

  typedef enum logic [1:0] {
    HBT_IDLE,
    HBT_READ,
    HBT_WRITE
  } hbt_cyc_t;

endpackage

// ===== sim/hbt_host_model.sv
`timescale 1ns/100ps
module hbt_host_model (
  input wire logic clk_sys,
  input wire logic style_68,
  input wire logic mux_mode,
  input wire logic [7:0] bus_level,
  output logic chip_select_n,
  output logic addr_latch,
  output logic data_strobe_n,
  output logic direction,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] addr_pins,
  output logic [7:0] drive_data,
  output logic drive_en
);
  initial
  begin
    {chip_select_n, data_strobe_n, direction, read_strobe_n, write_strobe_n} = 5'h1F;
    addr_latch = 1'b0;
    addr_pins = 3'h0;
    drive_data = 8'h00;
    drive_en = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Caller picks the gap, so spacing faults are commanded, never accidental
  task automatic bus_cycle(input logic wr, input logic [2:0] a, input logic [7:0] d,
    input int low, input int gap, output logic [7:0] rd);
    @(posedge clk_sys);
    chip_select_n <= 1'b0;
    addr_pins <= a;
    direction <= ~wr;
    drive_en <= wr;
    drive_data <= ~d;
    addr_latch <= mux_mode;
    if (mux_mode)
    begin
      @(posedge clk_sys);
      addr_latch <= 1'b0;
      repeat (2) @(posedge clk_sys);
      addr_pins <= ~a;
    end
    @(posedge clk_sys);
    if (style_68)
      data_strobe_n <= 1'b0;
    else if (wr)
      write_strobe_n <= 1'b0;
    else
      read_strobe_n <= 1'b0;
    repeat (low / 2) @(posedge clk_sys);
    drive_data <= d;
    repeat (low - low / 2) @(posedge clk_sys);
    rd = bus_level;
    {data_strobe_n, read_strobe_n, write_strobe_n} <= 3'h7;
    @(posedge clk_sys);
    chip_select_n <= 1'b1;
    direction <= 1'b1;
    drive_en <= 1'b0;
    addr_pins <= ~a;
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule

// ===== sim/tb_hbt_host_port.sv
`timescale 1ns/100ps
module tb_hbt_host_port;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] cfg_q = 6'b000010;
  logic cs_n, ale, ds_n, dir, rd_n, wr_n, h_en;
  logic [2:0] h_a, reg_addr_q;
  logic [7:0] h_d, bus, rdata, data_out_q, reg_wdata_q, got;
  logic data_oe_q, reg_wr_q, reg_rd_q, arb_tick_q, fast_read_q, write_enable_q, spacing_error_q;
  int failures = 0;
  int check_count = 0;
  int n_rd = 0, n_wr = 0, n_err = 0, n_tick = 0, n0;
  always #50 clk_sys = ~clk_sys;
  // Released data pins float up through their pull-ups
  assign bus = data_oe_q ? data_out_q : (h_en ? h_d : 8'hFF);
  assign rdata = 8'hA0 | {5'h00, reg_addr_q};
  hbt_host_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .chip_select_n(cs_n), .addr_latch(ale),
    .data_strobe_n(ds_n), .direction(dir), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .bus_timing_pin(cfg_q[1]), .mux_mode_pin(cfg_q[4]), .large_package(cfg_q[0]),
    .strobe_style_68(cfg_q[5]), .addr_in(h_a), .data_in(bus), .slow_arbitration_select(cfg_q[3]),
    .read_timing_select_bit(cfg_q[2]), .reg_rdata(rdata), .data_out_q(data_out_q),
    .data_oe_q(data_oe_q), .reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q),
    .reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q), .arb_tick_q(arb_tick_q),
    .fast_read_q(fast_read_q), .write_enable_q(write_enable_q),
    .spacing_error_q(spacing_error_q));
  hbt_host_model host (.clk_sys(clk_sys), .style_68(cfg_q[5]), .mux_mode(cfg_q[4]),
    .bus_level(bus), .chip_select_n(cs_n), .addr_latch(ale), .data_strobe_n(ds_n),
    .direction(dir), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr_pins(h_a),
    .drive_data(h_d), .drive_en(h_en));
  always @(posedge clk_sys)
  begin
    n_rd <= n_rd + int'(reg_rd_q === 1'b1);
    n_wr <= n_wr + int'(reg_wr_q === 1'b1);
    n_err <= n_err + int'(spacing_error_q === 1'b1);
    n_tick <= n_tick + int'(arb_tick_q === 1'b1);
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Order: style_68, mux, slow, read bit, timing pin, large package
  task automatic cfg(input logic [5:0] v);
    @(posedge clk_sys);
    cfg_q <= v;
    repeat (6) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_arb;
    cfg(6'b000010);
    n0 = n_tick;
    repeat (8) @(posedge clk_sys);
    chk(8'(n_tick - n0), 8'h08, "ticks fast");
    cfg(6'b001010);
    n0 = n_tick;
    repeat (8) @(posedge clk_sys);
    chk(8'(n_tick - n0), 8'h04, "ticks slow");
    $display("test arb done");
  endtask
  task automatic t_read;
    cfg(6'b000010);
    n0 = n_rd;
    host.bus_cycle(1'b0, hbt_pkg::ADDR_DATA, 8'h00, 6, 8, got);
    chk(got, 8'hA4, "read data");
    chk(8'(n_rd - n0), 8'h01, "read pulses");
    chk({5'h00, reg_addr_q}, 8'h04, "read addr");
    chk({7'h00, data_oe_q}, 8'h00, "bus released");
    chk({7'h00, fast_read_q}, 8'h01, "fast read");
    cfg(6'b100010);
    host.bus_cycle(1'b0, hbt_pkg::ADDR_PTR_HI, 8'h00, 6, 8, got);
    chk(got, 8'hA2, "strobe and direction read");
    chk({7'h00, data_oe_q}, 8'h00, "bus released again");
    $display("test read done");
  endtask
  task automatic t_write;
    cfg(6'b100010);
    n0 = n_wr;
    host.bus_cycle(1'b1, 3'h1, 8'h5A, 4, 8, got);
    chk(reg_wdata_q, 8'h5A, "write data");
    cfg(6'b100001);
    chk({6'h00, write_enable_q, fast_read_q}, 8'h00, "pin low");
    host.bus_cycle(1'b1, 3'h1, 8'hC3, 4, 8, got);
    chk(reg_wdata_q, 8'h5A, "write blocked");
    cfg(6'b100111);
    chk({6'h00, write_enable_q, fast_read_q}, 8'h02, "read bit set");
    host.bus_cycle(1'b1, 3'h1, 8'h3C, 4, 8, got);
    chk(reg_wdata_q, 8'h3C, "write ok");
    chk(8'(n_wr - n0), 8'h02, "write pulses");
    $display("test write done");
  endtask
  task automatic t_mux;
    cfg(6'b010010);
    host.bus_cycle(1'b0, 3'h6, 8'h00, 6, 8, got);
    chk({5'h00, reg_addr_q}, 8'h06, "latched addr");
    chk(got, 8'hA6, "mux read");
    cfg(6'b110010);
    host.bus_cycle(1'b1, 3'h5, 8'h96, 4, 8, got);
    chk({5'h00, reg_addr_q}, 8'h05, "mux write addr");
    chk(reg_wdata_q, 8'h96, "mux write data");
    $display("test mux done");
  endtask
  task automatic pair(input logic s, input logic sl, input logic w1, input logic [2:0] a1,
    input logic w2, input logic [2:0] a2, input int gap, input logic [7:0] exp);
    cfg({s, 1'b0, sl, 3'b010});
    n0 = n_err;
    host.bus_cycle(w1, a1, 8'h11, 3, gap, got);
    host.bus_cycle(w2, a2, 8'h22, 3, 8, got);
    chk(8'(n_err - n0), exp, "spacing flags");
  endtask
  task automatic t_space;
    // Trail to lead is gap plus three clocks, lead to lead gap plus six
    pair(1'b0, 1'b0, 1'b0, hbt_pkg::ADDR_DATA, 1'b0, hbt_pkg::ADDR_PTR_HI, 1, 8'h01);
    pair(1'b0, 1'b0, 1'b1, hbt_pkg::ADDR_DATA, 1'b0, hbt_pkg::ADDR_PTR_LO, 1, 8'h01);
    pair(1'b0, 1'b0, 1'b1, hbt_pkg::ADDR_PTR_LO, 1'b0, 3'h0, 0, 8'h01);
    pair(1'b1, 1'b0, 1'b1, hbt_pkg::ADDR_DATA, 1'b1, hbt_pkg::ADDR_PTR_LO, 1, 8'h01);
    pair(1'b0, 1'b0, 1'b0, hbt_pkg::ADDR_DATA, 1'b1, hbt_pkg::ADDR_PTR_LO, 1, 8'h01);
    // Gaps of exactly the minimum must pass; six clocks between leads flags only with slow ticks
    pair(1'b0, 1'b0, 1'b0, hbt_pkg::ADDR_DATA, 1'b0, hbt_pkg::ADDR_PTR_HI, 2, 8'h00);
    pair(1'b0, 1'b0, 1'b1, hbt_pkg::ADDR_PTR_LO, 1'b0, 3'h0, 1, 8'h00);
    pair(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 3'h1, 0, 8'h01);
    pair(1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h1, 0, 8'h00);
    $display("test spacing done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_arb;
    t_read;
    t_write;
    t_mux;
    t_space;
    wrap_up;
  end
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (6000) @(posedge clk_sys);
    failures++;
    wrap_up;
  end
endmodule
